/* File: psm_pkg.sv */
// Package for the power state manager: register indices, field layouts,
// reset values, command codes, timing counts and the state record types.
// Assumes a 25 MHz system clock and the indexed register port of the top.
package psm_pkg;

    // Register indices on the indexed register port.
    localparam logic [7:0] PSM_IDX_STATE_CAUSE  = 8'hc0;
    localparam logic [7:0] PSM_IDX_INTR_GATE    = 8'hc4;
    localparam logic [7:0] PSM_IDX_SLEEP_MAP    = 8'hc8;
    localparam logic [7:0] PSM_IDX_SUSPEND_MAP  = 8'hc9;
    localparam logic [7:0] PSM_IDX_FIRST_IDLE   = 8'hcc;
    localparam logic [7:0] PSM_IDX_SECOND_IDLE  = 8'hcd;
    localparam logic [7:0] PSM_IDX_DEEP_IDLE    = 8'hce;
    localparam logic [7:0] PSM_IDX_WAKE_DIV     = 8'hda;
    localparam logic [7:0] PSM_IDX_ACTIVITY     = 8'hdb;

    // Reset values.
    localparam logic [7:0] PSM_RST_INTR_GATE    = 8'hff;
    localparam logic [7:0] PSM_RST_SLEEP_MAP    = 8'h0c;
    localparam logic [7:0] PSM_RST_SUSPEND_MAP  = 8'h00;
    localparam logic [7:0] PSM_RST_TIMER        = 8'h00;
    localparam logic [7:0] PSM_RST_WAKE_DIV     = 8'h00;
    localparam logic [7:0] PSM_ACTIVE_MAP       = 8'hff;
    localparam logic [7:0] PSM_OFF_MAP          = 8'h00;

    // State/cause register fields.
    localparam int PSM_F_STATE_LO   = 0;
    localparam int PSM_F_OFF_SEL    = 2;
    localparam int PSM_F_RESUME     = 3;
    localparam int PSM_F_WAKE_LO    = 4;
    localparam int PSM_F_CAUSE_LO   = 6;

    // Two-bit state field codes.
    localparam logic [1:0] PSM_CODE_ON      = 2'h0;
    localparam logic [1:0] PSM_CODE_DOZE    = 2'h1;
    localparam logic [1:0] PSM_CODE_SLEEP   = 2'h2;
    localparam logic [1:0] PSM_CODE_SUSPEND = 2'h3;

    // Wake source codes.
    localparam logic [1:0] PSM_WAKE_NONE    = 2'h0;
    localparam logic [1:0] PSM_WAKE_SWITCH  = 2'h1;
    localparam logic [1:0] PSM_WAKE_RTC     = 2'h2;
    localparam logic [1:0] PSM_WAKE_RING    = 2'h3;

    // Interrupt cause codes.
    localparam logic [1:0] PSM_CAUSE_NONE   = 2'h0;
    localparam logic [1:0] PSM_CAUSE_SLEEP  = 2'h1;
    localparam logic [1:0] PSM_CAUSE_DEEP   = 2'h2;
    localparam logic [1:0] PSM_CAUSE_SWITCH = 2'h3;

    // Gate bits: a one masks the source.
    localparam int PSM_G_SWITCH = 1;
    localparam int PSM_G_SLEEP  = 4;
    localparam int PSM_G_DEEP   = 5;

    // Divider/status register fields.
    localparam int PSM_D_DOZE8  = 0;
    localparam int PSM_D_SLEEP8 = 1;
    localparam int PSM_D_STATIC = 2;
    localparam int PSM_D_REFPND = 7;

    // Timing: timers count in ticks of one second.
    localparam longint PSM_CLK_HZ     = 25_000_000;
    localparam longint PSM_TICK_S     = 1;
    localparam int     PSM_TICK_CYC   = int'(PSM_TICK_S * PSM_CLK_HZ);
    localparam int     PSM_TICK_W     = 26;
    localparam logic [2:0] PSM_DIV4_LAST = 3'h3;
    localparam logic [2:0] PSM_DIV8_LAST = 3'h7;
    localparam logic [3:0] PSM_RESET_CYC = 4'hf;
    localparam logic [3:0] PSM_REFR_CYC  = 4'h8;

    typedef enum logic [2:0] {PSM_ON, PSM_DOZE, PSM_SLEEP, PSM_SUSPEND, PSM_OFF} psm_state_t;

    // Indexed register port request.
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] index;
        logic [7:0] wdata;
    } psm_req_t;

    // Wake and event pins after synchronising.
    typedef struct packed {
        logic sw;
        logic ri;
        logic rtc;
    } psm_pins_t;

    typedef struct packed {
        psm_state_t            st;
        logic [1:0]            wake_code;
        logic                  resume;
        logic [1:0]            cause;
        logic                  nmi;
        logic [7:0]            gate;
        logic [7:0]            sleep_map;
        logic [7:0]            susp_map;
        logic [7:0]            doze_tmr;
        logic [7:0]            sleep_tmr;
        logic [7:0]            deep_tmr;
        logic [2:0]            div_cfg;
        logic                  sw_nmi_en;
        logic [7:0]            activity;
        logic [PSM_TICK_W-1:0] tick_cnt;
        logic [7:0]            idle_cnt;
        logic [7:0]            deep_cnt;
        logic                  sleep_fired;
        logic                  deep_fired;
        logic [2:0]            div_cnt;
        psm_pins_t             s1;
        psm_pins_t             s2;
        psm_pins_t             prev;
        logic [3:0]            rst_cnt;
        logic [3:0]            ref_cnt;
        logic [7:0]            rdata;
        logic                  cpu_clk_en;
        logic                  cpu_rst;
        logic [7:0]            pins;
        logic                  refresh_en;
    } psm_regs_t;

endpackage

/* File: psm_power_state_manager.sv */
// Power state manager: ON, DOZE, SLEEP, SUSPEND and OFF states, idle timers,
// CPU clock division and stopping, interrupt requests and wake recording.
// Assumes the CPU drives the indexed register port on mclk, activity and
// interrupt/DMA requests come from logic on mclk, and the three wake pins
// arrive asynchronously.

module psm_power_state_manager
    import psm_pkg::*;
#(
    parameter int TICK_CYCLES = PSM_TICK_CYC
)(
    input  wire logic       mclk,
    input  wire logic       resetn,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    input  wire logic [7:0] reg_index,
    input  wire logic [7:0] reg_wdata,
    output logic      [7:0] reg_rdata,
    input  wire logic [7:0] activity_in,
    input  wire logic       irq_dma_req,
    input  wire logic       power_switch_input,
    input  wire logic       ring_detect_input,
    input  wire logic       rtc_alarm,
    output logic            cpu_clk_en,
    output logic            cpu_reset,
    output logic            nmi_out,
    output logic      [7:0] power_ctl_pins,
    output logic            refresh_en
);

    localparam logic [PSM_TICK_W-1:0] TICK_LAST = PSM_TICK_W'(TICK_CYCLES - 1);

    psm_regs_t r_q;
    psm_regs_t r_d;
    psm_req_t  req;
    psm_pins_t pin_raw;

    assign req     = '{wr: reg_wr, rd: reg_rd, index: reg_index, wdata: reg_wdata};
    assign pin_raw = '{sw: power_switch_input, ri: ring_detect_input, rtc: rtc_alarm};

    // Maps a state onto its two-bit field code.
    function automatic logic [1:0] state_code(input psm_state_t s);
        logic [1:0] c;
        c = PSM_CODE_ON;
        unique case (s)
            PSM_ON:      c = PSM_CODE_ON;
            PSM_DOZE:    c = PSM_CODE_DOZE;
            PSM_SLEEP:   c = PSM_CODE_SLEEP;
            PSM_SUSPEND: c = PSM_CODE_SUSPEND;
            PSM_OFF:     c = PSM_CODE_SUSPEND;
        endcase
        return c;
    endfunction

    // Next-state logic for the whole manager.
    always_comb
    begin
        logic       tick;
        logic       any_act;
        logic       sw_rise;
        logic       ri_rise;
        logic       rtc_rise;
        logic       wr_state;
        logic       rd_gate;
        logic       rd_state;
        logic       rd_act;
        logic       slow;
        logic       div8;
        logic [2:0] div_last;
        psm_state_t nxt;

        r_d      = r_q;
        tick     = (r_q.tick_cnt == TICK_LAST);
        any_act  = |activity_in;
        sw_rise  = r_q.s2.sw & ~r_q.prev.sw;
        ri_rise  = r_q.s2.ri & ~r_q.prev.ri;
        rtc_rise = r_q.s2.rtc & ~r_q.prev.rtc;
        wr_state = req.wr && (req.index == PSM_IDX_STATE_CAUSE);
        rd_gate  = req.rd && (req.index == PSM_IDX_INTR_GATE);
        rd_state = req.rd && (req.index == PSM_IDX_STATE_CAUSE);
        rd_act   = req.rd && (req.index == PSM_IDX_ACTIVITY);
        nxt      = r_q.st;

        // Wake pins pass two flip-flops before any edge detection.
        r_d.s1   = pin_raw;
        r_d.s2   = r_q.s1;
        r_d.prev = r_q.s2;

        // Free-running one-second tick for the idle timers.
        r_d.tick_cnt = tick ? '0 : r_q.tick_cnt + 1'b1;

        // Register writes other than the state field.
        if (req.wr)
        begin
            unique case (req.index)
                PSM_IDX_INTR_GATE:   r_d.gate      = req.wdata;
                PSM_IDX_SLEEP_MAP:   r_d.sleep_map = req.wdata;
                PSM_IDX_SUSPEND_MAP: r_d.susp_map  = req.wdata;
                PSM_IDX_FIRST_IDLE:  r_d.doze_tmr  = req.wdata;
                PSM_IDX_SECOND_IDLE: r_d.sleep_tmr = req.wdata;
                PSM_IDX_DEEP_IDLE:   r_d.deep_tmr  = req.wdata;
                PSM_IDX_WAKE_DIV:
                begin
                    r_d.div_cfg   = req.wdata[2:0];
                    r_d.sw_nmi_en = 1'b1;
                end
                default: ;
            endcase
        end

        // Read-side effects; any hardware set further down wins over them.
        if (rd_gate)
            r_d.nmi = 1'b0;
        if (rd_state)
            r_d.resume = 1'b0;
        if (rd_act)
            r_d.activity = '0;
        if (wr_state && (req.wdata[PSM_F_CAUSE_LO +: 2] == PSM_CAUSE_NONE))
            r_d.cause = PSM_CAUSE_NONE;

        // Idle counter restarts on any activity and saturates otherwise.
        if (any_act)
        begin
            r_d.idle_cnt    = '0;
            r_d.sleep_fired = 1'b0;
        end
        else if (tick && (r_q.idle_cnt != 8'hff))
            r_d.idle_cnt = r_q.idle_cnt + 8'h01;

        // Automatic transitions driven by timers, activity and wake pins.
        unique case (r_q.st)
            PSM_ON:
            begin
                if (!any_act && (r_q.doze_tmr != PSM_RST_TIMER) && (r_q.idle_cnt >= r_q.doze_tmr))
                begin
                    nxt          = PSM_DOZE;
                    r_d.idle_cnt = '0;
                end
            end
            PSM_DOZE, PSM_SLEEP:
            begin
                if (any_act)
                begin
                    nxt          = PSM_ON;
                    r_d.activity = r_d.activity | activity_in;
                end
                else if ((r_q.st == PSM_DOZE) && (r_q.sleep_tmr != PSM_RST_TIMER)
                         && (r_q.idle_cnt >= r_q.sleep_tmr) && !r_q.sleep_fired)
                begin
                    r_d.sleep_fired = 1'b1;
                    if (!r_q.gate[PSM_G_SLEEP])
                    begin
                        r_d.nmi   = 1'b1;
                        r_d.cause = PSM_CAUSE_SLEEP;
                    end
                    else
                        nxt = PSM_SLEEP;
                end
            end
            PSM_SUSPEND, PSM_OFF:
            begin
                if (sw_rise || rtc_rise || ri_rise)
                begin
                    nxt        = PSM_ON;
                    r_d.resume = 1'b1;
                    if (sw_rise)
                        r_d.wake_code = PSM_WAKE_SWITCH;
                    else if (rtc_rise)
                        r_d.wake_code = PSM_WAKE_RTC;
                    else
                        r_d.wake_code = PSM_WAKE_RING;
                    if (r_q.st == PSM_OFF)
                        r_d.rst_cnt = PSM_RESET_CYC;
                    else
                        r_d.ref_cnt = PSM_REFR_CYC;
                end
            end
        endcase

        // Software state commands take priority over automatic moves.
        if (wr_state)
        begin
            unique case (req.wdata[PSM_F_STATE_LO +: 2])
                PSM_CODE_ON:    nxt = PSM_ON;
                PSM_CODE_DOZE:  nxt = PSM_DOZE;
                PSM_CODE_SLEEP:
                begin
                    if (r_q.st != PSM_SUSPEND && r_q.st != PSM_OFF)
                        nxt = PSM_SLEEP;
                end
                PSM_CODE_SUSPEND:
                begin
                    if (r_q.st != PSM_SUSPEND && r_q.st != PSM_OFF)
                    begin
                        nxt           = req.wdata[PSM_F_OFF_SEL] ? PSM_OFF : PSM_SUSPEND;
                        r_d.wake_code = PSM_WAKE_NONE;
                    end
                end
            endcase
        end
        if (nxt != r_q.st)
            r_d.idle_cnt = '0;

        // Deep timer counts time spent in SLEEP and fires once per visit.
        if (r_q.st != PSM_SLEEP)
        begin
            r_d.deep_cnt   = '0;
            r_d.deep_fired = 1'b0;
        end
        else
        begin
            if (tick && (r_q.deep_cnt != 8'hff))
                r_d.deep_cnt = r_q.deep_cnt + 8'h01;
            if ((r_q.deep_tmr != PSM_RST_TIMER) && (r_q.deep_cnt >= r_q.deep_tmr)
                && !r_q.deep_fired && !r_q.gate[PSM_G_DEEP])
            begin
                r_d.deep_fired = 1'b1;
                r_d.nmi        = 1'b1;
                r_d.cause      = PSM_CAUSE_DEEP;
            end
        end

        // Power switch request while running; the edge is not lost to a clear.
        if (sw_rise && r_q.sw_nmi_en && !r_q.gate[PSM_G_SWITCH]
            && (r_q.st == PSM_ON || r_q.st == PSM_DOZE || r_q.st == PSM_SLEEP))
        begin
            r_d.nmi   = 1'b1;
            r_d.cause = PSM_CAUSE_SWITCH;
        end

        // CPU reset after OFF and refresh-pending window after SUSPEND.
        if (r_q.rst_cnt != 4'h0)
            r_d.rst_cnt = r_q.rst_cnt - 4'h1;
        if (r_q.ref_cnt != 4'h0)
            r_d.ref_cnt = r_q.ref_cnt - 4'h1;

        r_d.st = nxt;

        // CPU clock: stopped in SUSPEND, OFF and during CPU reset, else full in ON or while a request is served, else divided or stopped.
        slow     = (nxt == PSM_DOZE) || (nxt == PSM_SLEEP);
        div8     = (nxt == PSM_SLEEP) ? r_q.div_cfg[PSM_D_SLEEP8] : r_q.div_cfg[PSM_D_DOZE8];
        div_last = div8 ? PSM_DIV8_LAST : PSM_DIV4_LAST;
        r_d.div_cnt = (r_q.div_cnt >= div_last) ? 3'h0 : r_q.div_cnt + 3'h1;
        if (nxt == PSM_SUSPEND || nxt == PSM_OFF || r_d.rst_cnt != 4'h0)
            r_d.cpu_clk_en = 1'b0;
        else if (!slow || irq_dma_req)
            r_d.cpu_clk_en = 1'b1;
        else if (r_q.div_cfg[PSM_D_STATIC])
            r_d.cpu_clk_en = 1'b0;
        else
            r_d.cpu_clk_en = (r_q.div_cnt == 3'h0);

        // Power pins follow the state being entered.
        unique case (nxt)
            PSM_ON, PSM_DOZE: r_d.pins = PSM_ACTIVE_MAP;
            PSM_SLEEP:        r_d.pins = r_q.sleep_map;
            PSM_SUSPEND:      r_d.pins = r_q.susp_map;
            PSM_OFF:          r_d.pins = PSM_OFF_MAP;
        endcase
        r_d.refresh_en = (nxt == PSM_SUSPEND);
        r_d.cpu_rst    = (r_d.rst_cnt != 4'h0);

        // Registered read data, one cycle after the read strobe.
        r_d.rdata = 8'h00;
        if (req.rd)
        begin
            unique case (req.index)
                PSM_IDX_STATE_CAUSE: r_d.rdata = {r_q.cause, r_q.wake_code, r_q.resume,
                                                  1'b0, state_code(r_q.st)};
                PSM_IDX_INTR_GATE:   r_d.rdata = r_q.gate;
                PSM_IDX_SLEEP_MAP:   r_d.rdata = r_q.sleep_map;
                PSM_IDX_SUSPEND_MAP: r_d.rdata = r_q.susp_map;
                PSM_IDX_FIRST_IDLE:  r_d.rdata = r_q.doze_tmr;
                PSM_IDX_SECOND_IDLE: r_d.rdata = r_q.sleep_tmr;
                PSM_IDX_DEEP_IDLE:   r_d.rdata = r_q.deep_tmr;
                PSM_IDX_WAKE_DIV:    r_d.rdata = {(r_q.ref_cnt != 4'h0), 4'h0, r_q.div_cfg};
                PSM_IDX_ACTIVITY:    r_d.rdata = r_q.activity;
                default:             r_d.rdata = 8'h00;
            endcase
        end
    end

    // State register; synchronous reset leaves the CPU running in ON.
    always_ff @(posedge mclk)
    begin
        if (!resetn)
        begin
            r_q            <= '0;
            r_q.st         <= PSM_ON;
            r_q.gate       <= PSM_RST_INTR_GATE;
            r_q.sleep_map  <= PSM_RST_SLEEP_MAP;
            r_q.susp_map   <= PSM_RST_SUSPEND_MAP;
            r_q.doze_tmr   <= PSM_RST_TIMER;
            r_q.sleep_tmr  <= PSM_RST_TIMER;
            r_q.deep_tmr   <= PSM_RST_TIMER;
            r_q.div_cfg    <= PSM_RST_WAKE_DIV[2:0];
            r_q.cpu_clk_en <= 1'b1;
            r_q.pins       <= PSM_ACTIVE_MAP;
        end
        else
            r_q <= r_d;
    end

    assign reg_rdata      = r_q.rdata;
    assign cpu_clk_en     = r_q.cpu_clk_en;
    assign cpu_reset      = r_q.cpu_rst;
    assign nmi_out        = r_q.nmi;
    assign power_ctl_pins = r_q.pins;
    assign refresh_en     = r_q.refresh_en;

endmodule

/* File: psm_power_state_manager_assertions.sv */
// Port-level checker for the power state manager.
// Assumes mclk and synchronous active-low resetn.
module psm_power_state_manager_assertions
    import psm_pkg::*;
(
    input wire logic       mclk,
    input wire logic       resetn,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_index,
    input wire logic [7:0] reg_wdata,
    input wire logic       irq_dma_req,
    input wire logic       power_switch_input,
    input wire logic       cpu_clk_en,
    input wire logic       cpu_reset,
    input wire logic       nmi_out,
    input wire logic [7:0] power_ctl_pins,
    input wire logic       refresh_en
);
    logic [7:0] sleep_q;
    logic [7:0] susp_q;
    logic       sw_mask_q;
    logic       sw_en_q;
    logic       c0_wr;

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!resetn);

    // Write to the state field.
    assign c0_wr = reg_wr && reg_index == PSM_IDX_STATE_CAUSE;

    // Shadows rebuilt from port traffic.
    always_ff @(posedge mclk)
    begin
        if (!resetn)
        begin
            sleep_q   <= PSM_RST_SLEEP_MAP;
            susp_q    <= PSM_RST_SUSPEND_MAP;
            sw_mask_q <= PSM_RST_INTR_GATE[PSM_G_SWITCH];
            sw_en_q   <= 1'b0;
        end
        else if (reg_wr)
        begin
            if (reg_index == PSM_IDX_SLEEP_MAP) sleep_q <= reg_wdata;
            if (reg_index == PSM_IDX_SUSPEND_MAP) susp_q <= reg_wdata;
            if (reg_index == PSM_IDX_INTR_GATE) sw_mask_q <= reg_wdata[PSM_G_SWITCH];
            if (reg_index == PSM_IDX_WAKE_DIV) sw_en_q <= 1'b1;
        end
    end

    property p_gate_read;
        reg_rd && reg_index == PSM_IDX_INTR_GATE |=> !nmi_out;
    endproperty
    a_gate_read: assert property (p_gate_read)
        else $error("interrupt still pending after gate read");

    property p_suspend;
        c0_wr && reg_wdata[2:0] == 3'h3 |=> ##1 !cpu_clk_en && refresh_en && power_ctl_pins == susp_q;
    endproperty
    a_suspend: assert property (p_suspend)
        else $error("suspend entry did not stop clock or apply map");

    property p_off;
        c0_wr && reg_wdata[2:0] == 3'h7 |=> ##1 !cpu_clk_en && !refresh_en && power_ctl_pins == PSM_OFF_MAP;
    endproperty
    a_off: assert property (p_off)
        else $error("off entry wrong");

    property p_cold_start;
        $rose(cpu_reset) |-> (cpu_reset && !cpu_clk_en) [*8];
    endproperty
    a_cold_start: assert property (p_cold_start)
        else $error("cpu reset too short or clock running");

    property p_warm_resume;
        $fell(refresh_en) |-> (!cpu_reset) [*8];
    endproperty
    a_warm_resume: assert property (p_warm_resume)
        else $error("cpu reset after suspend resume");

    property p_serviced;
        irq_dma_req && !refresh_en && !cpu_reset |=> cpu_clk_en;
    endproperty
    a_serviced: assert property (p_serviced)
        else $error("no full clock while servicing request");

    property p_switch_nmi;
        $rose(power_switch_input) && !sw_mask_q && sw_en_q |-> ##[1:6] nmi_out;
    endproperty
    a_switch_nmi: assert property (p_switch_nmi)
        else $error("no interrupt on switch edge");

    property p_sleep_map;
        c0_wr && reg_wdata[1:0] == PSM_CODE_SLEEP && !refresh_en |=> ##1 power_ctl_pins == sleep_q;
    endproperty
    a_sleep_map: assert property (p_sleep_map)
        else $error("sleep map not applied");
endmodule

bind psm_power_state_manager psm_power_state_manager_assertions u_psm_chk (.*);

/* File: psm_wake_source.sv */
// Far-side model: power switch, ring line and alarm source.
// Assumes one wake pulse at a time, on mclk.
module psm_wake_source
    import psm_pkg::*;
(
    input  wire logic       mclk,
    input  wire logic       go,
    input  wire logic [1:0] sel,
    output logic            sw,
    output logic            ri,
    output logic            rtc
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] len_q = 3'h0;
    logic [1:0] sel_q = 2'h0;

    // Four-cycle pulses, long enough to cross the input synchroniser.
    always_ff @(posedge mclk)
    begin
        if (go)
        begin
            len_q <= 3'h4;
            sel_q <= sel;
        end
        else if (len_q != 3'h0)
            len_q <= len_q - 3'h1;
    end

    // Lines rest low between pulses, as a tied-down ring line does.
    assign sw  = len_q != 3'h0 && sel_q == PSM_WAKE_SWITCH;
    assign ri  = len_q != 3'h0 && sel_q == PSM_WAKE_RING;
    assign rtc = len_q != 3'h0 && sel_q == PSM_WAKE_RTC;
endmodule

/* File: psm_power_state_manager_tb.sv */
// Self-checking bench for the power state manager.
// Assumes TICK_CYCLES of 4: one timer tick is four cycles.
module psm_power_state_manager_tb
    import psm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int TICK = 4;
    logic       mclk = 1'b0;
    logic       resetn = 1'b0;
    logic       reg_wr = 1'b0;
    logic       reg_rd = 1'b0;
    logic [7:0] reg_index = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic [7:0] activity_in = 8'h00;
    logic       irq_dma_req = 1'b0;
    logic       go = 1'b0;
    logic [1:0] sel = 2'h0;
    logic [7:0] reg_rdata, power_ctl_pins, v, smap, pmap, act;
    logic       cpu_clk_en, cpu_reset, nmi_out, refresh_en, sw, ri, rtc;
    logic [7:0] idxs [10] = '{8'hc0, 8'hc4, 8'hc8, 8'hc9, 8'hcc, 8'hcd, 8'hce, 8'hda, 8'hdb, 8'he0};
    logic [7:0] divs [3] = '{8'h00, 8'h01, 8'h04};
    logic [1:0] srcs [3] = '{PSM_WAKE_SWITCH, PSM_WAKE_RTC, PSM_WAKE_RING};
    int         errors = 0;
    int         total_checks = 0;
    int         seed = 32'h91dee8cc;
    int         n;

    psm_power_state_manager #(.TICK_CYCLES(TICK)) DUT (
        .power_switch_input(sw), .ring_detect_input(ri), .rtc_alarm(rtc), .*
    );
    psm_wake_source u_far (.*);

    // Free-running 25 MHz clock.
    initial
    begin
        forever #20 mclk = ~mclk;
    end

    // Expected values come from the rules, not the design.
    function automatic logic [7:0] rst_val(input logic [7:0] idx);
        if (idx == PSM_IDX_INTR_GATE) return PSM_RST_INTR_GATE;
        return (idx == PSM_IDX_SLEEP_MAP) ? PSM_RST_SLEEP_MAP : 8'h00;
    endfunction
    function automatic logic [7:0] exp_clk(input logic [7:0] div, input int b8);
        if (div[PSM_D_STATIC]) return 8'h00;
        return div[b8] ? 8'h04 : 8'h08;
    endfunction

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            errors++;
            $display("[FAIL] %0t ns: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] idx, input logic [7:0] dat);
        @(negedge mclk);
        reg_wr = 1'b1;
        reg_index = idx;
        reg_wdata = dat;
        @(negedge mclk);
        reg_wr = 1'b0;
    endtask
    task automatic rd(input logic [7:0] idx, output logic [7:0] dat);
        @(negedge mclk);
        reg_rd = 1'b1;
        reg_index = idx;
        @(negedge mclk);
        reg_rd = 1'b0;
        dat = reg_rdata;
    endtask
    task automatic state_is(input logic [1:0] code);
        rd(PSM_IDX_STATE_CAUSE, v);
        chk({6'h0, v[1:0]}, {6'h0, code});
    endtask
    // Counts high cycles of clock enable or reset.
    task automatic count_hi(input int w, input bit rst, output int c);
        c = 0;
        repeat (w)
        begin
            @(negedge mclk);
            if ((rst ? cpu_reset : cpu_clk_en) === 1'b1) c++;
        end
    endtask
    task automatic wake(input logic [1:0] s);
        @(negedge mclk);
        go = 1'b1;
        sel = s;
        @(negedge mclk);
        go = 1'b0;
    endtask
    // Firmware-style wait: running state seen and refresh no longer pending.
    task automatic poll(output logic [7:0] st);
        logic [7:0] dv;
        logic       res;
        res = 1'b0;
        st = 8'h03;
        dv = 8'h80;
        for (int k = 0; k < 40 && (st[1:0] != PSM_CODE_ON || dv[PSM_D_REFPND]); k++)
        begin
            rd(PSM_IDX_STATE_CAUSE, st);
            res |= st[PSM_F_RESUME];
            rd(PSM_IDX_WAKE_DIV, dv);
        end
        st[PSM_F_RESUME] = res;
    endtask
    task automatic do_reset();
        resetn = 1'b0;
        repeat (5) @(negedge mclk);
        resetn = 1'b1;
    endtask
    task automatic end_of_test();
        if (errors == 0 && total_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // Main sequence.
    initial
    begin
        do_reset();
        wr(8'he0, 8'($random(seed)));
        foreach (idxs[i])
        begin
            rd(idxs[i], v);
            chk(v, rst_val(idxs[i]));
        end
        smap = 8'($random(seed));
        pmap = 8'($random(seed));
        wr(PSM_IDX_SLEEP_MAP, smap);
        wr(PSM_IDX_SUSPEND_MAP, pmap);
        rd(PSM_IDX_SUSPEND_MAP, v);
        chk(v, pmap);
        wr(PSM_IDX_FIRST_IDLE, 8'h02);
        repeat (4 * TICK) @(negedge mclk);
        state_is(PSM_CODE_DOZE);
        foreach (divs[i])
        begin
            wr(PSM_IDX_WAKE_DIV, divs[i]);
            count_hi(32, 1'b0, n);
            chk(8'(n), exp_clk(divs[i], PSM_D_DOZE8));
        end
        irq_dma_req = 1'b1;
        repeat (4) @(negedge mclk);
        irq_dma_req = 1'b0;
        state_is(PSM_CODE_DOZE);
        act = 8'($random(seed)) | 8'h01;
        activity_in = act;
        repeat (2) @(negedge mclk);
        activity_in = 8'h00;
        state_is(PSM_CODE_ON);
        rd(PSM_IDX_ACTIVITY, v);
        chk(v, act);
        wr(PSM_IDX_FIRST_IDLE, 8'h00);
        wr(PSM_IDX_STATE_CAUSE, {6'h0, PSM_CODE_DOZE});
        state_is(PSM_CODE_DOZE);
        wr(PSM_IDX_STATE_CAUSE, {6'h0, PSM_CODE_SLEEP});
        state_is(PSM_CODE_SLEEP);
        wr(PSM_IDX_WAKE_DIV, 8'h02);
        count_hi(32, 1'b0, n);
        chk(8'(n), exp_clk(8'h02, PSM_D_SLEEP8));
        wr(PSM_IDX_STATE_CAUSE, {6'h0, PSM_CODE_ON});
        state_is(PSM_CODE_ON);
        chk(power_ctl_pins, PSM_ACTIVE_MAP);
        wr(PSM_IDX_INTR_GATE, 8'hef);
        wr(PSM_IDX_SECOND_IDLE, 8'h01);
        wr(PSM_IDX_FIRST_IDLE, 8'h01);
        repeat (12 * TICK) @(negedge mclk);
        chk({7'h0, nmi_out}, 8'h01);
        rd(PSM_IDX_STATE_CAUSE, v);
        chk({v[7:6], 4'h0, v[1:0]}, {PSM_CAUSE_SLEEP, 4'h0, PSM_CODE_DOZE});
        rd(PSM_IDX_INTR_GATE, v);
        chk({7'h0, nmi_out}, 8'h00);
        wr(PSM_IDX_INTR_GATE, 8'hff);
        // The timeout fires once per idle period, so a new period is begun.
        activity_in = 8'h01;
        @(negedge mclk);
        activity_in = 8'h00;
        repeat (8 * TICK) @(negedge mclk);
        state_is(PSM_CODE_SLEEP);
        chk(power_ctl_pins, smap);
        wr(PSM_IDX_DEEP_IDLE, 8'h02);
        wr(PSM_IDX_INTR_GATE, 8'hdf);
        repeat (12 * TICK) @(negedge mclk);
        rd(PSM_IDX_STATE_CAUSE, v);
        chk({v[7:6], 3'h0, v[1:0], nmi_out}, {PSM_CAUSE_DEEP, 3'h0, PSM_CODE_SLEEP, 1'b1});
        rd(PSM_IDX_INTR_GATE, v);
        chk({7'h0, nmi_out}, 8'h00);
        wr(PSM_IDX_INTR_GATE, 8'hff);
        wr(PSM_IDX_FIRST_IDLE, 8'h00);
        wr(PSM_IDX_SECOND_IDLE, 8'h00);
        wr(PSM_IDX_DEEP_IDLE, 8'h00);
        foreach (srcs[i])
        begin
            wr(PSM_IDX_STATE_CAUSE, 8'h03);
            repeat (10) @(negedge mclk);
            chk({power_ctl_pins[6:0], refresh_en}, {pmap[6:0], 1'b1});
            wake(srcs[i]);
            poll(v);
            chk({v[5:3], v[1:0]}, {srcs[i], 1'b1, PSM_CODE_ON});
            rd(PSM_IDX_STATE_CAUSE, v);
            chk({7'h0, v[PSM_F_RESUME]}, 8'h00);
        end
        wr(PSM_IDX_STATE_CAUSE, 8'h07);
        repeat (10) @(negedge mclk);
        chk(power_ctl_pins, PSM_OFF_MAP);
        wake(PSM_WAKE_RING);
        count_hi(40, 1'b1, n);
        chk(8'(n), {4'h0, PSM_RESET_CYC});
        poll(v);
        chk({6'h0, v[5:4]}, {6'h0, PSM_WAKE_RING});
        do_reset();
        wr(PSM_IDX_INTR_GATE, 8'hfd);
        wake(PSM_WAKE_SWITCH);
        repeat (8) @(negedge mclk);
        chk({7'h0, nmi_out}, 8'h00);
        wr(PSM_IDX_WAKE_DIV, 8'h00);
        wake(PSM_WAKE_SWITCH);
        repeat (8) @(negedge mclk);
        rd(PSM_IDX_STATE_CAUSE, v);
        chk({v[7:6], 5'h0, nmi_out}, {PSM_CAUSE_SWITCH, 5'h0, 1'b1});
        end_of_test();
    end

    // Watchdog: the sequence needs about 600 cycles.
    initial
    begin
        #(40 * 8000);
        errors++;
        end_of_test();
    end
endmodule
